// [verilog/pps_port_power_status.sv]
`timescale 1ns/1ps
`default_nettype none

module pps_port_power_status
    import pps_pkg::*;
#(
    parameter int N          = PORTS,
    parameter int INRUSH_CYC = INRUSH_CYCLES
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // Register read port behind the serial interface
    input  wire logic             reg_rd,
    input  wire logic [7:0]       reg_addr,
    output logic      [7:0]       reg_rdata,
    output logic                  reg_rvalid,
    // Mode and per-port enables
    input  wire logic             managed_mode,
    input  wire logic [N-1:0]     probe_en,
    // Front end events and levels
    input  wire pps_port_in_t     port_in [N],
    // Front end control
    output logic      [N-1:0]     det_start,
    output logic      [N-1:0]     cls_start,
    output logic      [N-1:0]     cls_reset,
    output logic      [N-1:0]     gate_on,
    output logic      [N-1:0]     inrush_limit,
    output logic      [N-1:0]     monitor_en,
    // Per-port status
    output logic      [N*4-1:0]   det_result,
    output logic      [N*4-1:0]   class_result_field,
    output logic      [N-1:0]     class_complete_flag,
    output logic      [N-1:0]     switch_change,
    output logic      [N-1:0]     settled_change
);

    pps_state_t   st [N];
    logic [N-1:0] port_switch_on;
    logic [N-1:0] port_power_settled;
    logic [N-1:0] on_d;
    logic [N-1:0] good_d;
    logic [N-1:0] pwr_pend;
    logic [N-1:0] svc_req;
    logic [N-1:0] grant;
    logic [N-1:0] tmr_start;
    logic [N-1:0] tmr_done;

    // A port queues here until the arbiter hands it the shared front end
    pps_service_arb #(
        .N        (N)
    ) u_arb (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .req      (svc_req),
        .grant    (grant)
    );

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_port
            logic fault_cut;

            assign svc_req[i] = (st[i] == ST_WAIT) || (st[i] == ST_DETECT)
                             || (st[i] == ST_CLASS) || (st[i] == ST_CRESET);
            assign tmr_start[i] = (st[i] == ST_CLASS) && port_in[i].cls_done
                               && pwr_pend[i] && (port_in[i].cls_code != CLS_MISMATCH);
            assign fault_cut = port_in[i].current_limit_event || port_in[i].overpower_cut_event || port_in[i].disc;

            pps_inrush_timer #(
                .CYCLES   (INRUSH_CYC)
            ) u_tmr (
                .ref_clk  (ref_clk),
                .sys_rst  (sys_rst),
                .start    (tmr_start[i]),
                .run      (st[i] == ST_INRUSH),
                .done     (tmr_done[i])
            );

            // Pushbutton request stays pending until the port is powered or off
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    pwr_pend[i] <= 1'b0;
                end else if (port_in[i].off_req || tmr_start[i]) begin
                    pwr_pend[i] <= 1'b0;
                end else if (port_in[i].pb_req) begin
                    pwr_pend[i] <= 1'b1;
                end
            end

            // Port sequencer
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    st[i] <= ST_IDLE;
                end else if (port_in[i].off_req) begin
                    st[i] <= ST_IDLE;
                end else begin
                    case (st[i])
                        ST_IDLE: begin
                            if (pwr_pend[i] || port_in[i].pb_req
                                || (managed_mode && probe_en[i])) begin
                                st[i] <= ST_WAIT;
                            end
                        end
                        ST_WAIT: begin
                            if (grant[i]) begin
                                st[i] <= ST_DETECT;
                            end
                        end
                        ST_DETECT: begin
                            // Detection includes the connection check
                            if (port_in[i].det_done) begin
                                if (port_in[i].det_code == DET_VALID_SIG) begin
                                    st[i] <= ST_CLASS;
                                end else begin
                                    st[i] <= ST_IDLE;
                                end
                            end
                        end
                        ST_CLASS: begin
                            if (port_in[i].cls_done) begin
                                if (port_in[i].cls_code == CLS_MISMATCH) begin
                                    st[i] <= ST_CRESET;
                                end else if (pwr_pend[i]) begin
                                    st[i] <= ST_INRUSH;
                                end else begin
                                    st[i] <= ST_IDLE;
                                end
                            end
                        end
                        ST_CRESET: begin
                            st[i] <= ST_CLASS;
                        end
                        ST_INRUSH: begin
                            if (tmr_done[i]) begin
                                if (port_in[i].drain_low) begin
                                    st[i] <= ST_SETTLED;
                                end else begin
                                    st[i] <= ST_IDLE;
                                end
                            end
                        end
                        ST_SETTLED: begin
                            if (fault_cut) begin
                                st[i] <= ST_IDLE;
                            end
                        end
                        default: begin
                            st[i] <= ST_IDLE;
                        end
                    endcase
                end
            end

            // Status bits follow the sequencer; both fall in the same edge
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    port_switch_on[i]     <= 1'b0;
                    port_power_settled[i] <= 1'b0;
                end else if (port_in[i].off_req
                             || (st[i] == ST_SETTLED && fault_cut)
                             || (st[i] == ST_INRUSH && tmr_done[i]
                                 && !port_in[i].drain_low)) begin
                    port_switch_on[i]     <= 1'b0;
                    port_power_settled[i] <= 1'b0;
                end else if (tmr_start[i]) begin
                    port_switch_on[i]     <= 1'b1;
                end else if (st[i] == ST_INRUSH && tmr_done[i]) begin
                    port_power_settled[i] <= 1'b1;
                end
            end

            // Front end drive
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    det_start[i]    <= 1'b0;
                    cls_start[i]    <= 1'b0;
                    cls_reset[i]    <= 1'b0;
                    gate_on[i]      <= 1'b0;
                    inrush_limit[i] <= 1'b0;
                    monitor_en[i]   <= 1'b0;
                end else begin
                    det_start[i]    <= (st[i] == ST_DETECT);
                    cls_start[i]    <= (st[i] == ST_CLASS);
                    cls_reset[i]    <= (st[i] == ST_CLASS) && port_in[i].cls_done
                                    && (port_in[i].cls_code == CLS_MISMATCH);
                    gate_on[i]      <= port_switch_on[i];
                    inrush_limit[i] <= port_switch_on[i] && !port_power_settled[i];
                    monitor_en[i]   <= port_power_settled[i];
                end
            end

            // Detection and class results
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    det_result[i*4 +: 4]         <= DET_UNKNOWN;
                    class_result_field[i*4 +: 4] <= CLS_UNKNOWN;
                    class_complete_flag[i]       <= 1'b0;
                end else begin
                    class_complete_flag[i] <= (st[i] == ST_CLASS)
                                           && port_in[i].cls_done;
                    if (st[i] == ST_DETECT && port_in[i].det_done) begin
                        // Capacitive and PSE-to-PSE codes pass through unchanged
                        det_result[i*4 +: 4] <= port_in[i].det_code;
                        if (port_in[i].det_code == DET_VALID_SIG) begin
                            class_result_field[i*4 +: 4] <= CLS_UNKNOWN;
                        end
                    end
                    if (st[i] == ST_CLASS && port_in[i].cls_done) begin
                        if (port_in[i].cls_code == CLS_T1_LIMITED && !pwr_pend[i]) begin
                            class_result_field[i*4 +: 4] <= CLS_CLASS4;
                        end else begin
                            class_result_field[i*4 +: 4] <= port_in[i].cls_code;
                        end
                    end
                end
            end

            // Change flags, one cycle after the bit moves
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    on_d[i]           <= 1'b0;
                    good_d[i]         <= 1'b0;
                    switch_change[i]  <= 1'b0;
                    settled_change[i] <= 1'b0;
                end else begin
                    on_d[i]           <= port_switch_on[i];
                    good_d[i]         <= port_power_settled[i];
                    switch_change[i]  <= port_switch_on[i] ^ on_d[i];
                    settled_change[i] <= port_power_settled[i] ^ good_d[i];
                end
            end

            a_off_clears_both: assert property (@(posedge ref_clk) disable iff (sys_rst)
                $fell(port_switch_on[i]) |-> !port_power_settled[i])
                else $error("settled bit outlived switch on");

            a_settled_needs_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
                port_power_settled[i] |-> port_switch_on[i])
                else $error("settled without switch on");

            a_settle_drain_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
                $rose(port_power_settled[i]) |-> $past(port_in[i].drain_low)
                                              && $past(tmr_done[i]))
                else $error("settled without inrush end and low drain");

            a_no_limited_probe: assert property (@(posedge ref_clk) disable iff (sys_rst)
                (st[i] == ST_CLASS && port_in[i].cls_done && !pwr_pend[i])
                |=> class_result_field[i*4 +: 4] != CLS_T1_LIMITED)
                else $error("limited class code during probe");

            a_mismatch_retry: assert property (@(posedge ref_clk) disable iff (sys_rst)
                (st[i] == ST_CLASS && port_in[i].cls_done
                 && port_in[i].cls_code == CLS_MISMATCH && !port_in[i].off_req)
                |=> cls_reset[i] && st[i] == ST_CRESET ##1 st[i] == ST_CLASS)
                else $error("mismatch did not reset and retry class");

            a_class_after_sig: assert property (@(posedge ref_clk) disable iff (sys_rst)
                $rose(st[i] == ST_CLASS) && $past(st[i]) == ST_DETECT
                |-> $past(port_in[i].det_code) == DET_VALID_SIG)
                else $error("class started without valid signature");

            a_sig_clears_class: assert property (@(posedge ref_clk) disable iff (sys_rst)
                (st[i] == ST_DETECT && port_in[i].det_done
                 && port_in[i].det_code == DET_VALID_SIG)
                |=> class_result_field[i*4 +: 4] == CLS_UNKNOWN)
                else $error("valid signature did not clear class result");

            a_det_code_kept: assert property (@(posedge ref_clk) disable iff (sys_rst)
                (st[i] == ST_DETECT && port_in[i].det_done)
                |=> det_result[i*4 +: 4] == $past(port_in[i].det_code))
                else $error("detection code not reported");

            a_switch_after_class: assert property (@(posedge ref_clk) disable iff (sys_rst)
                $rose(port_switch_on[i]) |-> $past(st[i]) == ST_CLASS
                                          && st[i] == ST_INRUSH)
                else $error("switch on without class power on");

            a_gate_follows: assert property (@(posedge ref_clk) disable iff (sys_rst)
                $rose(port_switch_on[i]) |=> gate_on[i])
                else $error("gate drive did not follow switch on");

            // The pulse shows the cycle after the bit moved, then drops unless it moved again
            a_change_marked: assert property (@(posedge ref_clk) disable iff (sys_rst)
                $changed(port_switch_on[i]) |=> switch_change[i]
                ##1 (!switch_change[i] || $changed(on_d[i])))
                else $error("switch change not flagged");

            a_settled_flagged: assert property (@(posedge ref_clk) disable iff (sys_rst)
                $changed(port_power_settled[i]) |=> settled_change[i]
                ##1 (!settled_change[i] || $changed(good_d[i])))
                else $error("settled change not flagged");

            a_inrush_limit: assert property (@(posedge ref_clk) disable iff (sys_rst)
                $rose(port_switch_on[i]) |=> inrush_limit[i])
                else $error("inrush current limit not allowed");

            a_monitor_settled: assert property (@(posedge ref_clk) disable iff (sys_rst)
                port_power_settled[i] |=> monitor_en[i])
                else $error("settled port not monitored");
        end
    endgenerate

    // Register read; a read only samples, never clears
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata  <= RST_PORT_POWER_STATE;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                if (reg_addr == ADDR_PORT_POWER_STATE) begin
                    reg_rdata <= '0;
                    reg_rdata[FLD_SWITCH_ON_LSB +: N] <= port_switch_on;
                    reg_rdata[FLD_SETTLED_LSB +: N]   <= port_power_settled;
                end else begin
                    reg_rdata <= READ_UNMAPPED;
                end
            end
        end
    end

    a_read_status: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd && reg_addr == ADDR_PORT_POWER_STATE
        |=> reg_rvalid && reg_rdata == {$past(port_power_settled), $past(port_switch_on)})
        else $error("status read mismatch");

endmodule : pps_port_power_status

`default_nettype wire

// [verilog/pps_pkg.sv]
package pps_pkg;

    localparam int         PORTS          = 4;
    localparam int         CODE_W         = 4;

    // Register map
    localparam logic [7:0] ADDR_PORT_POWER_STATE  = 8'h10;
    localparam logic [7:0] RST_PORT_POWER_STATE   = 8'h00;
    localparam int         FLD_SWITCH_ON_LSB      = 0;
    localparam int         FLD_SETTLED_LSB        = 4;
    localparam logic [7:0] READ_UNMAPPED          = 8'h00;

    // Detection result codes
    localparam logic [3:0] DET_UNKNOWN    = 4'h0;
    localparam logic [3:0] DET_CAPACITIVE = 4'h2;
    localparam logic [3:0] DET_VALID_SIG  = 4'h4;
    localparam logic [3:0] DET_PSE_TO_PSE = 4'h7;
    localparam logic [3:0] DET_SW_FAULT   = 4'hf;

    // Classification result codes
    localparam logic [3:0] CLS_UNKNOWN    = 4'h0;
    localparam logic [3:0] CLS_CLASS4     = 4'h4;
    localparam logic [3:0] CLS_T1_LIMITED = 4'hc;
    localparam logic [3:0] CLS_MISMATCH   = 4'hf;

    // Timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int INRUSH_US      = 60;
    localparam int INRUSH_CYCLES  = (INRUSH_US * 1000) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_WAIT    = 3'b001,
        ST_DETECT  = 3'b010,
        ST_CLASS   = 3'b011,
        ST_INRUSH  = 3'b100,
        ST_SETTLED = 3'b101,
        ST_CRESET  = 3'b110
    } pps_state_t;

    // Per-port events and levels from the analog front end
    typedef struct packed {
        logic       det_done;
        logic [3:0] det_code;
        logic       cls_done;
        logic [3:0] cls_code;
        logic       drain_low;
        logic       current_limit_event;
        logic       overpower_cut_event;
        logic       disc;
        logic       pb_req;
        logic       off_req;
    } pps_port_in_t;

endpackage : pps_pkg

// [verilog/pps_inrush_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module pps_inrush_timer
    import pps_pkg::*;
#(
    parameter int CYCLES = INRUSH_CYCLES
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Control
    input  wire logic start,
    input  wire logic run,
    // Status
    output logic      done
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count <= '0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= CW'(CYCLES - 1);
            end else if (run && count != '0) begin
                count <= count - 1'b1;
                if (count == CW'(1)) begin
                    done <= 1'b1;
                end
            end
        end
    end

endmodule : pps_inrush_timer

`default_nettype wire

// [verilog/pps_service_arb.sv]
`timescale 1ns/1ps
`default_nettype none

module pps_service_arb
    import pps_pkg::*;
#(
    parameter int N = PORTS
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    // Requests and grant
    input  wire logic [N-1:0] req,
    output logic      [N-1:0] grant
);

    logic [$clog2(N)-1:0] last;
    logic [N-1:0]         next_grant;

    // Round robin among requesting ports; a grant holds until its port drops the request, so a port retrying class keeps it
    function automatic logic [N-1:0] pick(input logic [N-1:0] r,
                                          input logic [$clog2(N)-1:0] from);
        logic [N-1:0] g;
        int           k;
        g = '0;
        for (int j = N; j >= 1; j--) begin
            k = (int'(from) + j) % N;
            if (r[k]) begin
                g = '0;
                g[k] = 1'b1;
            end
        end
        return g;
    endfunction : pick

    always_comb begin
        next_grant = pick(req, last);
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            grant <= '0;
            last  <= '0;
        end else if ((grant & req) == '0) begin
            grant <= next_grant;
            for (int j = 0; j < N; j++) begin
                if (next_grant[j]) begin
                    last <= ($clog2(N))'(j);
                end
            end
        end
    end

endmodule : pps_service_arb

`default_nettype wire

// [tb/pps_fe_model.sv]
`timescale 1ns/1ps
`default_nettype none

module pps_fe_model
    import pps_pkg::*;
#(
    parameter int N = PORTS
) (
    // Clock
    input  wire logic         ref_clk,
    // Front end control from the block
    input  wire logic [N-1:0] det_start,
    input  wire logic [N-1:0] cls_start,
    // Scenario settings from the bench
    input  wire logic [3:0]   det_code,
    input  wire logic [3:0]   cls_code,
    input  wire logic [N-1:0] drain_low,
    input  wire logic [N-1:0] fault,
    input  wire logic [N-1:0] pb,
    input  wire logic [N-1:0] off,
    // Events and levels to the block
    output var pps_port_in_t  port_in [N]
);
    int         cnt [N];
    logic [1:0] prev [N];

    // Each port answers after its own delay of 2 + i cycles; the arbiter lets only one port detect or classify at a time
    always @(negedge ref_clk) begin
        // Bench settings change on this same edge; sample them once settled
        #1;
        for (int i = 0; i < N; i++) begin
            prev[i] <= {det_start[i], cls_start[i]};
            cnt[i] <= ({det_start[i], cls_start[i]} != prev[i]) ? 0 : cnt[i] + 1;
            port_in[i].det_done <= det_start[i] && cnt[i] == 2 + i;
            // Codes are only valid during their phase; otherwise a junk value
            port_in[i].det_code <= det_start[i] ? det_code : ~det_code;
            port_in[i].cls_done <= cls_start[i] && cnt[i] == 2 + i;
            port_in[i].cls_code <= cls_start[i] ? cls_code : ~cls_code;
            port_in[i].drain_low <= drain_low[i];
            port_in[i].current_limit_event <= 1'b0;
            port_in[i].overpower_cut_event <= 1'b0;
            port_in[i].disc <= fault[i];
            port_in[i].pb_req <= pb[i];
            port_in[i].off_req <= off[i];
        end
    end
endmodule : pps_fe_model

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import pps_pkg::*;
    localparam int N   = 4;
    localparam int INR = 20;
    logic         ref_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         reg_rd = 1'b0;
    logic [7:0]   reg_addr = 8'h00;
    logic         managed_mode = 1'b0;
    logic [N-1:0] probe_en = '0, drain_low = '0, fault = '0, pb = '0, off = '0;
    logic [3:0]   det_code = DET_VALID_SIG, cls_code = CLS_CLASS4;
    pps_port_in_t port_in [N];
    logic [7:0]   reg_rdata;
    logic         reg_rvalid;
    logic [N-1:0] det_start, cls_start, cls_reset, gate_on, inrush_limit, monitor_en;
    logic [N-1:0] class_complete_flag, switch_change, settled_change;
    logic [N*4-1:0] det_result, class_result_field;
    int           err_total = 0, comparisons = 0, cycles = 0;

    pps_fe_model #(.N(N)) pps_fe_model_inst (.ref_clk(ref_clk), .det_start(det_start),
        .cls_start(cls_start), .det_code(det_code), .cls_code(cls_code),
        .drain_low(drain_low), .fault(fault), .pb(pb), .off(off), .port_in(port_in));

    pps_port_power_status #(.N(N), .INRUSH_CYC(INR)) pps_port_power_status_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .managed_mode(managed_mode),
        .probe_en(probe_en), .port_in(port_in), .det_start(det_start),
        .cls_start(cls_start), .cls_reset(cls_reset), .gate_on(gate_on),
        .inrush_limit(inrush_limit), .monitor_en(monitor_en), .det_result(det_result),
        .class_result_field(class_result_field), .class_complete_flag(class_complete_flag),
        .switch_change(switch_change), .settled_change(settled_change));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        reg_rd = 1'b1;
        reg_addr = addr;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        cmp("reg_rvalid", 8'h01, {7'h00, reg_rvalid});
        cmp("reg_rdata", exp, reg_rdata);
        @(negedge ref_clk);
    endtask : rd

    task automatic wait_gate(input int p);
        repeat (300) begin
            @(negedge ref_clk);
            if (gate_on[p] === 1'b1) break;
        end
    endtask : wait_gate

    task automatic power_up(input int p, input logic ok, input logic [7:0] others);
        drain_low[p] = ok;
        pb[p] = 1'b1;
        @(negedge ref_clk);
        pb[p] = 1'b0;
        wait_gate(p);
        cmp("gate_on", 8'h01, {7'h00, gate_on[p]});
        cmp("inrush_limit", 8'h01, {7'h00, inrush_limit[p]});
        rd(ADDR_PORT_POWER_STATE, others | (8'h01 << p));
        repeat (INR + 10) @(negedge ref_clk);
        cmp("monitor_en", {7'h00, ok}, {7'h00, monitor_en[p]});
        rd(ADDR_PORT_POWER_STATE, others | (ok ? (8'h11 << p) : 8'h00));
    endtask : power_up

    task automatic t_settle_and_off();
        logic seen;
        seen = 1'b0;
        power_up(0, 1'b1, 8'h00);
        rd(ADDR_PORT_POWER_STATE, 8'h11);
        power_up(2, 1'b1, 8'h11);
        off[0] = 1'b1;
        @(negedge ref_clk);
        off[0] = 1'b0;
        repeat (6) begin
            @(negedge ref_clk);
            seen |= (switch_change[0] === 1'b1) && (settled_change[0] === 1'b1);
        end
        cmp("change flags", 8'h01, {7'h00, seen});
        rd(ADDR_PORT_POWER_STATE, 8'h44);
        power_up(1, 1'b0, 8'h44);
    endtask : t_settle_and_off

    task automatic t_disconnect();
        fault[2] = 1'b1;
        repeat (5) @(negedge ref_clk);
        fault[2] = 1'b0;
        rd(ADDR_PORT_POWER_STATE, 8'h00);
    endtask : t_disconnect

    task automatic t_mismatch();
        logic       got, sr;
        logic [3:0] cf;
        got = 1'b0;
        sr = 1'b0;
        cf = 4'h0;
        cls_code = CLS_MISMATCH;
        drain_low[3] = 1'b1;
        pb[3] = 1'b1;
        @(negedge ref_clk);
        pb[3] = 1'b0;
        repeat (40) begin
            @(negedge ref_clk);
            // Read the class field only while the completion flag is up
            if (class_complete_flag[3] === 1'b1 && !got) begin
                got = 1'b1;
                cf = class_result_field[15:12];
                cls_code = CLS_CLASS4;
            end
            if (cls_reset[3] === 1'b1) sr = 1'b1;
        end
        cmp("class mismatch", {4'h0, CLS_MISMATCH}, {4'h0, cf});
        cmp("cls_reset", 8'h01, {7'h00, sr});
        wait_gate(3);
        repeat (INR + 10) @(negedge ref_clk);
        rd(ADDR_PORT_POWER_STATE, 8'h88);
        off[3] = 1'b1;
        @(negedge ref_clk);
        off[3] = 1'b0;
    endtask : t_mismatch

    task automatic t_managed();
        logic cls_seen, det_seen;
        logic [3:0] codes [2];
        cls_seen = 1'b0;
        det_seen = 1'b0;
        codes = '{DET_CAPACITIVE, DET_PSE_TO_PSE};
        managed_mode = 1'b1;
        foreach (codes[k]) begin
            det_code = codes[k];
            probe_en[0] = 1'b1;
            repeat (40) begin
                @(negedge ref_clk);
                cls_seen |= (cls_start[0] === 1'b1);
                det_seen |= (det_start[0] === 1'b1);
            end
            cmp("det_result", {4'h0, codes[k]}, {4'h0, det_result[3:0]});
        end
        cmp("cls_start", 8'h00, {7'h00, cls_seen});
        cmp("det_start", 8'h01, {7'h00, det_seen});
        det_code = DET_VALID_SIG;
        cls_code = CLS_T1_LIMITED;
        repeat (60) begin
            @(negedge ref_clk);
            if (class_complete_flag[0] === 1'b1) break;
        end
        cmp("probe class", {4'h0, CLS_CLASS4}, {4'h0, class_result_field[3:0]});
        probe_en[0] = 1'b0;
        managed_mode = 1'b0;
        repeat (20) @(negedge ref_clk);
        rd(ADDR_PORT_POWER_STATE, 8'h00);
    endtask : t_managed

    initial begin
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
        @(negedge ref_clk);
        rd(ADDR_PORT_POWER_STATE, RST_PORT_POWER_STATE);
        rd(8'h33, READ_UNMAPPED);
        t_settle_and_off();
        t_disconnect();
        t_mismatch();
        t_managed();
        wrap_up();
    end
endmodule : testbench

`default_nettype wire
